// *** common/static_mem_cfg.svh ***
// Constants of the static memory access sequencer.
// Assumes inclusion by the core module and the bench only.
`ifndef STATIC_MEM_CFG_SVH
`define STATIC_MEM_CFG_SVH
`define WAIT_OFF 2'h0
`define WAIT_FROZEN 2'h2
`define WAIT_READY 2'h3
`define SLOW_RD_SETUP 6'h01
`define SLOW_RD_PULSE 7'h01
`define SLOW_CS_RD_SETUP 6'h00
`define SLOW_CS_RD_PULSE 7'h02
`define SLOW_RD_CYCLE 9'h002
`define SLOW_WR_SETUP 6'h01
`define SLOW_WR_PULSE 7'h01
`define SLOW_CS_WR_SETUP 6'h00
`define SLOW_CS_WR_PULSE 7'h03
`define SLOW_WR_CYCLE 9'h003
`define TDF_MAX 4'hf
`endif

// *** common/static_mem_pkg.sv ***
// Types of the static memory access sequencer.
// Assumes the constants header alongside.
package static_mem_pkg;
   typedef struct packed {
      logic [5:0] strobe_setup;
      logic [6:0] strobe_pulse;
      logic [5:0] cs_setup;
      logic [6:0] cs_pulse;
      logic [8:0] cycle_len;
   } timing_s;
   typedef struct packed {
      logic [1:0] ext_wait_mode_field;
      logic read_mode;
      logic tdf_mode;
      logic [3:0] tdf_cycles;
   } cs_mode_s;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RUN = 3'b001,
      ST_READY_WAIT = 3'b011,
      ST_FLOAT = 3'b010,
      ST_RELOAD = 3'b110
   } seq_state_e;
endpackage

// *** core/static_mem_wait_slow.sv ***
// Per-access sequencer: float waits, external wait, slow clock mode.
// Assumes one master clock; requests held until acc_done.
//
// What this block does
// - Optimized float: setup of a next access to the same chip select counts toward float, insert only remainder.
// - Unoptimized float: append float waits after read before next access.
// - Unoptimized: read hold cycles overlapping float period count toward it.
// - Wait mode 10 frozen, 11 ready, 00 ignores the wait input.
// - Wait input sampled only during pulse phase of controlling strobe.
// - Frozen mode halts counters and outputs until wait released.
// - Ready mode tests wait in last pulse cycle and stalls there.
// - Ready mode: wait outside final pulse cycle leaves access length unchanged.
// - Strobe pulse must cover wait latency plus two sync plus one.
// - Slow clock indication replaces all timings by fixed read and write sets.
// - Fixed slow read 1/1/0/2/2, write 1/1/0/3/3 cycles.
// - Transfer started slow finishes with slow set after indication drops.
// - Float count ranges zero to fifteen master-clock cycles.
// - Slow mode entry or exit inserts one reload wait after transfer.
// - Float starts at read strobe or chip-select rise per read mode.
`timescale 1ns/1ns
`include "static_mem_cfg.svh"
module static_mem_wait_slow (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Access request
   input wire logic acc_req,
   input wire logic acc_write,
   input wire logic [2:0] acc_cs,
   output logic acc_done,
   // Per chip select configuration of the requested access
   input wire static_mem_pkg::timing_s rd_timing,
   input wire static_mem_pkg::timing_s wr_timing,
   input wire static_mem_pkg::cs_mode_s cs_mode_reg,
   // Power manager
   input wire logic slow_clk_ind,
   // Memory pins
   input wire logic ext_wait_n,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic chip_select_n,
   // Status
   output logic slow_active,
   output logic wait_stalled
);
   static_mem_pkg::seq_state_e state, next_state;
   logic [8:0] cnt, next_cnt;
   logic [3:0] tdf_left, next_tdf_left;
   logic slow, next_slow;
   logic cur_write, next_cur_write;
   logic [2:0] cur_cs, next_cur_cs;
   static_mem_pkg::timing_s tim, next_tim;
   static_mem_pkg::cs_mode_s mode, next_mode;
   logic rd_n, next_rd_n, wr_n, next_wr_n, cs_n, next_cs_n;
   logic done, next_done;
   logic wait_meta, wait_sync;
   logic strobe_pulse, cs_on, last_pulse, waiting, froze;

   // Only the second stage is looked at
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_meta <= 1'b0;
         wait_sync <= 1'b0;
      end else if (clk_en) begin
         wait_meta <= ~ext_wait_n;
         wait_sync <= wait_meta;
      end
   end

   function automatic logic in_win(input logic [8:0] c, input logic [5:0] s, input logic [6:0] p);
      in_win = (c >= {3'h0, s}) && (c < ({3'h0, s} + {2'h0, p}));
   endfunction

   always_comb begin
      strobe_pulse = in_win(cnt, tim.strobe_setup, tim.strobe_pulse);
      cs_on = in_win(cnt, tim.cs_setup, tim.cs_pulse);
      last_pulse = strobe_pulse && (cnt == ({3'h0, tim.strobe_setup} + {2'h0, tim.strobe_pulse} - 9'h001));
      // Wait ignored in slow mode and outside the strobe pulse
      waiting = !slow && wait_sync && (mode.ext_wait_mode_field != `WAIT_OFF);
      froze = (state == static_mem_pkg::ST_RUN) && waiting && strobe_pulse
              && (mode.ext_wait_mode_field == `WAIT_FROZEN);
   end

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_tdf_left = tdf_left;
      next_slow = slow;
      next_cur_write = cur_write;
      next_cur_cs = cur_cs;
      next_tim = tim;
      next_mode = mode;
      next_done = 1'b0;
      next_rd_n = 1'b1;
      next_wr_n = 1'b1;
      next_cs_n = 1'b1;
      case (state)
         static_mem_pkg::ST_IDLE, static_mem_pkg::ST_RELOAD: begin
            // Reload cycle doubles as the idle cycle before accept
            next_state = static_mem_pkg::ST_IDLE;
            if (slow != slow_clk_ind) begin
               next_slow = slow_clk_ind;
               next_state = static_mem_pkg::ST_RELOAD;
            end else if (acc_req) begin
               next_cur_write = acc_write;
               next_cur_cs = acc_cs;
               next_mode = cs_mode_reg;
               next_cnt = 9'h000;
               // Slow set latched here, kept to the end of the transfer
               if (slow) begin
                  next_tim = acc_write ? {`SLOW_WR_SETUP, `SLOW_WR_PULSE, `SLOW_CS_WR_SETUP,
                                          `SLOW_CS_WR_PULSE, `SLOW_WR_CYCLE}
                                       : {`SLOW_RD_SETUP, `SLOW_RD_PULSE, `SLOW_CS_RD_SETUP,
                                          `SLOW_CS_RD_PULSE, `SLOW_RD_CYCLE};
               end else begin
                  next_tim = acc_write ? wr_timing : rd_timing;
               end
               // Optimized float: setup of this access absorbs pending float
               if (mode.tdf_mode && acc_cs == cur_cs) begin
                  if ({2'h0, tdf_left} > next_tim.strobe_setup) begin
                     next_tdf_left = tdf_left - next_tim.strobe_setup[3:0];
                     next_state = static_mem_pkg::ST_FLOAT;
                  end else begin
                     next_tdf_left = 4'h0;
                     next_state = static_mem_pkg::ST_RUN;
                  end
               end else if (tdf_left != 4'h0) begin
                  next_state = static_mem_pkg::ST_FLOAT;
               end else begin
                  next_state = static_mem_pkg::ST_RUN;
               end
            end else if (tdf_left != 4'h0) begin
               next_tdf_left = tdf_left - 4'h1;
            end
         end
         static_mem_pkg::ST_FLOAT: begin
            next_tdf_left = tdf_left - 4'h1;
            if (tdf_left == 4'h1) begin
               next_state = static_mem_pkg::ST_RUN;
            end
         end
         static_mem_pkg::ST_RUN: begin
            next_rd_n = !(strobe_pulse && !cur_write);
            next_wr_n = !(strobe_pulse && cur_write);
            next_cs_n = !cs_on;
            if (froze) begin
               // Hold the pins exactly as they are
               next_rd_n = rd_n;
               next_wr_n = wr_n;
               next_cs_n = cs_n;
            end else if (last_pulse && waiting && mode.ext_wait_mode_field == `WAIT_READY) begin
               next_state = static_mem_pkg::ST_READY_WAIT;
            end else if (cnt + 9'h001 >= tim.cycle_len) begin
               next_state = static_mem_pkg::ST_IDLE;
               next_done = 1'b1;
               // Pins lag a cycle, so the last position still shows here
               // Float counted from strobe or cs rise; hold cycles already spent count
               if (!cur_write) begin
                  next_tdf_left = remain(mode, tim, cnt);
               end
            end else begin
               next_cnt = cnt + 9'h001;
            end
         end
         static_mem_pkg::ST_READY_WAIT: begin
            next_rd_n = rd_n;
            next_wr_n = wr_n;
            next_cs_n = cs_n;
            if (!wait_sync) begin
               next_cnt = cnt + 9'h001;
               next_state = static_mem_pkg::ST_RUN;
            end
         end
         default: begin
            next_state = static_mem_pkg::ST_IDLE;
         end
      endcase
   end

   function automatic logic [3:0] remain(input static_mem_pkg::cs_mode_s m,
                                         input static_mem_pkg::timing_s t, input logic [8:0] c);
      logic [8:0] rise;
      logic [8:0] spent;
      rise = m.read_mode ? ({3'h0, t.strobe_setup} + {2'h0, t.strobe_pulse})
                         : ({3'h0, t.cs_setup} + {2'h0, t.cs_pulse});
      spent = (c + 9'h001 > rise) ? (c + 9'h001 - rise) : 9'h000;
      remain = (spent >= {5'h00, m.tdf_cycles}) ? 4'h0 : (m.tdf_cycles - spent[3:0]);
   endfunction

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= static_mem_pkg::ST_IDLE;
         cnt <= 9'h000;
         tdf_left <= 4'h0;
         slow <= 1'b0;
         cur_write <= 1'b0;
         cur_cs <= 3'h0;
         tim <= '0;
         mode <= '0;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         cs_n <= 1'b1;
         done <= 1'b0;
      end else if (clk_en) begin
         state <= next_state;
         cnt <= next_cnt;
         tdf_left <= next_tdf_left;
         slow <= next_slow;
         cur_write <= next_cur_write;
         cur_cs <= next_cur_cs;
         tim <= next_tim;
         mode <= next_mode;
         rd_n <= next_rd_n;
         wr_n <= next_wr_n;
         cs_n <= next_cs_n;
         done <= next_done;
      end
   end

   assign read_strobe_n = rd_n;
   assign write_strobe_n = wr_n;
   assign chip_select_n = cs_n;
   assign acc_done = done;
   assign slow_active = slow;
   assign wait_stalled = froze || (state == static_mem_pkg::ST_READY_WAIT);

   chk_sync_two_stage: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && $past(clk_en) && $past(clk_en, 2) |-> wait_sync == $past(~ext_wait_n, 2))
      else $error("wait synchronizer depth wrong");
   chk_wait_off_ignored: assert property (@(posedge clk) disable iff (!rst_n)
      mode.ext_wait_mode_field == `WAIT_OFF |-> !wait_stalled)
      else $error("wait honoured while disabled");
   chk_wait_pulse_only: assert property (@(posedge clk) disable iff (!rst_n)
      state == static_mem_pkg::ST_RUN && !strobe_pulse && clk_en && (cnt + 9'h001 < tim.cycle_len)
      |=> cnt == $past(cnt) + 9'h001)
      else $error("wait acted outside strobe pulse");
   chk_frozen_hold: assert property (@(posedge clk) disable iff (!rst_n)
      froze && clk_en |=> $stable(cnt) && $stable(read_strobe_n) && $stable(write_strobe_n))
      else $error("frozen access moved");
   chk_ready_stall: assert property (@(posedge clk) disable iff (!rst_n)
      state == static_mem_pkg::ST_READY_WAIT && wait_sync |=> state == static_mem_pkg::ST_READY_WAIT || !clk_en)
      else $error("ready stall left while waiting");
   chk_slow_latch: assert property (@(posedge clk) disable iff (!rst_n)
      state == static_mem_pkg::ST_RUN && clk_en |=> $stable(tim))
      else $error("timing changed mid transfer");
   chk_reload_insert: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && $changed(slow) |-> state == static_mem_pkg::ST_RELOAD)
      else $error("no reload wait on slow mode change");
   chk_float_bound: assert property (@(posedge clk) disable iff (!rst_n)
      state == static_mem_pkg::ST_FLOAT |-> tdf_left != 4'h0 && tdf_left <= `TDF_MAX)
      else $error("float count out of range");
   chk_slow_write_len: assert property (@(posedge clk) disable iff (!rst_n)
      slow && state == static_mem_pkg::ST_RUN && cur_write |-> tim.cycle_len == `SLOW_WR_CYCLE)
      else $error("slow write cycle wrong");
endmodule

// *** verif/ext_wait_dev.sv ***
// External device model that stretches accesses through its wait line.
// Assumes active-low strobes and a wait line with a pull-up.
`timescale 1ns/1ns
module ext_wait_dev (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Memory pins
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic chip_select_n,
   output logic ext_wait_n,
   // Behaviour set by the bench
   input wire logic [7:0] latency,
   input wire logic [7:0] hold_len
);
   // Zero hold_len keeps the line released, so the pull-up level shows
   initial begin
      ext_wait_n = 1'b1;
      forever begin
         @(posedge clk);
         #1;
         if (rst_n && !chip_select_n && !(read_strobe_n && write_strobe_n) && hold_len != 8'h00) begin
            repeat (latency) @(posedge clk);
            #1 ext_wait_n = 1'b0;
            repeat (hold_len) @(posedge clk);
            #1 ext_wait_n = 1'b1;
            wait (read_strobe_n && write_strobe_n);
         end
      end
   end
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the access sequencer: float, wait, slow clock.
// Assumes the sequencer core and the wait device model beside it.
`timescale 1ns/1ns
`include "static_mem_cfg.svh"
module tb_top;
   logic clk, rst_n, acc_req, acc_write, acc_done, slow_clk_ind, ext_wait_n, stall;
   logic read_strobe_n, write_strobe_n, chip_select_n, slow_active, wait_stalled;
   logic [2:0] acc_cs;
   logic [7:0] latency, hold_len;
   static_mem_pkg::timing_s rd_timing, wr_timing;
   static_mem_pkg::cs_mode_s cs_mode_reg;
   int num_errors, check_count, len, lo, csl, base;
   int ftdf[5] = '{6, 15, 4, 0, 9};
   logic fmode[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
   // Float left after two hold cycles and one idle cycle, less the write setup when optimized
   int fext[5] = '{3, 12, 0, 0, 4};
   logic [1:0] wmode[5] = '{`WAIT_FROZEN, `WAIT_OFF, `WAIT_READY, `WAIT_FROZEN, `WAIT_READY};
   logic [7:0] wlat[5] = '{8'h01, 8'h01, 8'h01, 8'h09, 8'h09};
   logic [7:0] whold[5] = '{8'h04, 8'h04, 8'h02, 8'h02, 8'h02};
   int wext[5] = '{4, 0, 0, 0, 0};
   static_mem_wait_slow uut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .acc_req(acc_req),
      .acc_write(acc_write), .acc_cs(acc_cs), .acc_done(acc_done), .rd_timing(rd_timing),
      .wr_timing(wr_timing), .cs_mode_reg(cs_mode_reg), .slow_clk_ind(slow_clk_ind),
      .ext_wait_n(ext_wait_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
      .chip_select_n(chip_select_n), .slow_active(slow_active), .wait_stalled(wait_stalled));
   ext_wait_dev dev (.clk(clk), .rst_n(rst_n), .read_strobe_n(read_strobe_n),
      .write_strobe_n(write_strobe_n), .chip_select_n(chip_select_n), .ext_wait_n(ext_wait_n),
      .latency(latency), .hold_len(hold_len));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Counts cycles to done; one extra cycle catches the late strobe edge
   task automatic access(input logic wr);
      int n;
      n = 0;
      lo = 0;
      csl = 0;
      stall = 1'b0;
      acc_write = wr;
      acc_req = 1'b1;
      do begin
         @(negedge clk);
         n++;
         if (!read_strobe_n || !write_strobe_n) lo++;
         if (!chip_select_n) csl++;
         if (wait_stalled === 1'b1) stall = 1'b1;
      end while (acc_done !== 1'b1 && n < 400);
      acc_req = 1'b0;
      len = n;
      @(negedge clk);
      if (!read_strobe_n || !write_strobe_n) lo++;
   endtask
   task automatic final_report;
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      final_report();
   end
   initial begin
      rst_n = 1'b0;
      acc_req = 1'b0;
      acc_write = 1'b0;
      acc_cs = 3'h1;
      slow_clk_ind = 1'b0;
      latency = 8'h01;
      hold_len = 8'h00;
      // Pulse 8 covers latency plus sync plus one, hold of 2 cycles
      rd_timing = '{6'h02, 7'h08, 6'h00, 7'h0a, 9'h00c};
      wr_timing = rd_timing;
      cs_mode_reg = '{`WAIT_OFF, 1'b1, 1'b0, 4'h0};
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check({read_strobe_n, write_strobe_n, chip_select_n, slow_active, acc_done}, 5'h1c);
      access(1'b1);
      access(1'b1);
      base = len;
      $display("test reset and baseline done");
      for (int i = 0; i < 5; i++) begin
         cs_mode_reg = '{`WAIT_OFF, 1'b1, fmode[i], ftdf[i][3:0]};
         access(1'b0);
         access(1'b1);
         check(len, base + fext[i]);
      end
      $display("test float waits done");
      for (int i = 0; i < 5; i++) begin
         cs_mode_reg = '{wmode[i], 1'b1, 1'b0, 4'h0};
         latency = wlat[i];
         hold_len = whold[i];
         access(1'b1);
         check(len, base + wext[i]);
         check(lo, 8 + wext[i]);
         check(stall, wext[i] != 0);
      end
      cs_mode_reg = '{`WAIT_READY, 1'b1, 1'b0, 4'h0};
      latency = 8'h01;
      hold_len = 8'h0c;
      access(1'b1);
      check(len > base, 1'b1);
      check(stall, 1'b1);
      $display("test external wait done");
      // Wait input stays off while slow waveforms run
      hold_len = 8'h00;
      cs_mode_reg = '{`WAIT_OFF, 1'b1, 1'b0, 4'h0};
      slow_clk_ind = 1'b1;
      access(1'b1);
      check(len, base - 8);
      check(lo, 1);
      check(csl, 3);
      access(1'b0);
      check(len, base - 10);
      check(lo, 1);
      check(csl, 2);
      check(slow_active, 1'b1);
      fork
         access(1'b1);
         begin
            @(negedge clk);
            @(negedge clk);
            slow_clk_ind = 1'b0;
         end
      join
      check(len, base - 9);
      // Reload already spent in the idle gap after the cut transfer
      access(1'b1);
      check(len, base);
      check(slow_active, 1'b0);
      $display("test slow clock done");
      final_report();
   end
endmodule
